// >>> pkg/obse_pkg.sv
// Package for the output bank source and driver enable block
package obse_pkg;
  // ****************************************
  // Geometry and register map
  // ****************************************
  localparam int NUM_BANKS = 7;
  localparam logic [7:0] BANK_CFG_BASE = 8'h00; // Bank n at base + n
  localparam logic [7:0] DRV_EN_BASE = 8'h08; // Driver n at base + n
  localparam logic [7:0] BYPASS_CFG_ADDR = 8'h10;
  localparam logic [7:0] BYPASS_CFG_MASK = 8'h0F;
  localparam logic [7:0] BANK_CFG_MASK = 8'h3F;
  localparam logic [7:0] BANK_CFG_NOFAN_MASK = 8'h27;
  localparam logic [7:0] DRV_EN_MASK = 8'hC1;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BANK_POWER_DOWN_BIT = 5;
  localparam int FAN_LSB = 3;
  localparam int SRC_LSB = 0;
  localparam int DRV_PD_BIT = 7;
  localparam int DRV_MODE_BIT = 6;
  localparam int DRV_DIS_BIT = 0;
  localparam int BYP_G0_BIT = 0;
  localparam int BYP_S0_BIT = 1;
  localparam int BYP_G1_BIT = 2;
  localparam int BYP_S1_BIT = 3;
  localparam logic [7:0] BANK_CFG_RESET = 8'h05;
  localparam logic [7:0] DRV_EN_RESET = 8'h00;
  localparam logic [7:0] BYPASS_RESET = 8'h00;
  localparam int FANOUT_FIRST_BANK = 4;
  // ****************************************
  // Codes
  // ****************************************
  localparam logic [1:0] FAN_NORMAL = 2'h0;
  localparam logic [1:0] FAN_INPUT0 = 2'h1;
  localparam logic [1:0] FAN_INPUT1 = 2'h2;
  localparam logic [2:0] SRC_INT0_DIV1 = 3'h0;
  localparam logic [2:0] SRC_INT1_REF = 3'h1;
  localparam logic [2:0] SRC_INT2 = 3'h2;
  localparam logic [2:0] SRC_INT3 = 3'h3;
  localparam logic [2:0] SRC_FRAC0 = 3'h4;
  localparam logic [2:0] SRC_FRAC1 = 3'h5;
  localparam logic [2:0] SRC_FRAC2 = 3'h6;
  localparam logic [2:0] SRC_DIV0 = 3'h7;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0] integer_divider;
    logic [2:0] fractional_divider;
    logic clock_input_0;
    logic clock_input_1;
    logic divided_input_0;
    logic divided_input_1;
    logic reference_divided;
  } obse_sources_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } obse_req_t;
endpackage : obse_pkg

// >>> hw/obse_top.sv
// Output bank source selection and per-driver enable logic
// What this block does
// - Bank power-down field 1 powers the bank down; 0 keeps it up.
// - Fan-out mode selection exists only on banks 4, 5 and 6.
// - Bank fan-out mode works only with the device-level bypass enabled.
// - Fan-out mode 0 runs the bank from its source-select field.
// - Fan-out mode 1 takes clock input 0 when its select bit is 1.
// - Fan-out mode 2 takes clock input 1 when its select bit is 1.
// - Codes 0 to 3 pick integer dividers, divided input 1 or reference.
// - Codes 4 to 7 pick fractional dividers or divided input 0.
// - Codes not valid for a bank are reserved for that bank.
// - Source-select field resets to 5, fractional divider 1.
// - Driver power-down bit 1 powers the driver down; 0 keeps it up.
// - Enable mode 0 switches the driver glitchlessly on a falling edge of the bank clock.
// - Enable mode 1 switches the driver at once, glitches possible.
module obse_top #(
  parameter int BANKS = obse_pkg::NUM_BANKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire obse_pkg::obse_req_t req,
  output logic [7:0] rd_data_q,
  // Source clocks, sampled as levels
  input wire obse_pkg::obse_sources_t sources,
  // Bank and driver outputs
  output logic [BANKS-1:0] bank_clk_q,
  output logic [BANKS-1:0] bank_power_down_q,
  output logic [BANKS-1:0] driver_power_down_q,
  output logic [BANKS-1:0] driver_out_q,
  output logic [BANKS-1:0] bank_reserved_q
);
  import obse_pkg::*;

  if (BANKS != NUM_BANKS) begin : g_bad_banks
    $error("obse_top serves exactly seven banks");
  end

  // ****************************************
  // Functions
  // ****************************************
  // Validity of a source code on a bank
  function automatic logic src_valid(input int bank, input logic [2:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      SRC_INT0_DIV1: ok = (bank <= 1) || (bank >= 4);
      SRC_INT1_REF: ok = (bank <= 2) || (bank == 5);
      SRC_INT2: ok = (bank >= 4);
      SRC_INT3: ok = (bank >= 5);
      SRC_FRAC0: ok = (bank <= 3);
      SRC_FRAC1: ok = 1'b1;
      SRC_FRAC2: ok = (bank >= 3);
      SRC_DIV0: ok = (bank >= 4);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Clock level selected by a source code on a bank
  function automatic logic src_level(input int bank, input logic [2:0] code, input obse_sources_t s);
    logic lvl;
    lvl = 1'b0;
    case (code)
      SRC_INT0_DIV1: lvl = (bank <= 1) ? s.integer_divider[0] : s.divided_input_1;
      SRC_INT1_REF: lvl = (bank <= 2) ? s.integer_divider[1] : s.reference_divided;
      SRC_INT2: lvl = s.integer_divider[2];
      SRC_INT3: lvl = s.integer_divider[3];
      SRC_FRAC0: lvl = s.fractional_divider[0];
      SRC_FRAC1: lvl = s.fractional_divider[1];
      SRC_FRAC2: lvl = s.fractional_divider[2];
      SRC_DIV0: lvl = s.divided_input_0;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] bank_cfg_q [BANKS];
  logic [7:0] bank_cfg_d [BANKS];
  logic [7:0] drv_en_q [BANKS];
  logic [7:0] drv_en_d [BANKS];
  logic [7:0] bypass_q;
  logic [7:0] bypass_d;
  logic [7:0] rd_data_d;

  // Writes and read mux
  always_comb begin
    bypass_d = bypass_q;
    rd_data_d = 8'h00;
    for (int b = 0; b < BANKS; b++) begin
      bank_cfg_d[b] = bank_cfg_q[b];
      drv_en_d[b] = drv_en_q[b];
      if (req.wr && req.addr == BANK_CFG_BASE + 8'(b)) begin
        // Reserved bits and fan-out field on low banks stay zero
        bank_cfg_d[b] = req.wdata & ((b >= FANOUT_FIRST_BANK) ? BANK_CFG_MASK : BANK_CFG_NOFAN_MASK);
      end
      if (req.wr && req.addr == DRV_EN_BASE + 8'(b)) begin
        drv_en_d[b] = req.wdata & DRV_EN_MASK;
      end
      if (req.rd && req.addr == BANK_CFG_BASE + 8'(b)) begin
        rd_data_d = bank_cfg_q[b];
      end
      if (req.rd && req.addr == DRV_EN_BASE + 8'(b)) begin
        rd_data_d = drv_en_q[b];
      end
    end
    if (req.wr && req.addr == BYPASS_CFG_ADDR) begin
      bypass_d = req.wdata & BYPASS_CFG_MASK;
    end
    if (req.rd && req.addr == BYPASS_CFG_ADDR) begin
      rd_data_d = bypass_q;
    end
  end

  // Register storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int b = 0; b < BANKS; b++) begin
        bank_cfg_q[b] <= BANK_CFG_RESET;
        drv_en_q[b] <= DRV_EN_RESET;
      end
      bypass_q <= BYPASS_RESET;
      rd_data_q <= 8'h00;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        bank_cfg_q[b] <= bank_cfg_d[b];
        drv_en_q[b] <= drv_en_d[b];
      end
      bypass_q <= bypass_d;
      rd_data_q <= rd_data_d;
    end
  end

  // ****************************************
  // Source selection and driver gating
  // ****************************************
  logic [BANKS-1:0] bank_clk_d;
  logic [BANKS-1:0] bank_reserved_d;
  logic [BANKS-1:0] gate_q;
  logic [BANKS-1:0] gate_d;
  logic [BANKS-1:0] driver_out_d;
  logic [BANKS-1:0] bank_power_down_d;
  logic [BANKS-1:0] driver_power_down_d;
  logic [BANKS-1:0] bypass0_act;
  logic [BANKS-1:0] bypass1_act;

  // Per-bank clock pick and enable gate
  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      logic [1:0] fan;
      logic [2:0] code;
      logic want;
      fan = bank_cfg_q[b][FAN_LSB +: 2];
      code = bank_cfg_q[b][SRC_LSB +: 3];
      want = ~drv_en_q[b][DRV_DIS_BIT];
      bypass0_act[b] = (fan == FAN_INPUT0) && bypass_q[BYP_G0_BIT] && bypass_q[BYP_S0_BIT];
      bypass1_act[b] = (fan == FAN_INPUT1) && bypass_q[BYP_G1_BIT] && bypass_q[BYP_S1_BIT];
      bank_reserved_d[b] = 1'b0;
      if (bypass0_act[b]) begin
        bank_clk_d[b] = sources.clock_input_0;
      end else if (bypass1_act[b]) begin
        bank_clk_d[b] = sources.clock_input_1;
      end else begin
        // Reserved codes hold the bank clock low
        bank_reserved_d[b] = ~src_valid(b, code);
        bank_clk_d[b] = src_level(b, code, sources) & ~bank_reserved_d[b];
      end
      bank_power_down_d[b] = bank_cfg_q[b][BANK_POWER_DOWN_BIT];
      driver_power_down_d[b] = drv_en_q[b][DRV_PD_BIT];
      if (drv_en_q[b][DRV_MODE_BIT]) begin
        gate_d[b] = want;
      end else if (bank_clk_q[b] && !bank_clk_d[b]) begin
        gate_d[b] = want;
      end else begin
        gate_d[b] = gate_q[b];
      end
      driver_out_d[b] = bank_clk_d[b] & gate_d[b] & ~bank_power_down_d[b] & ~driver_power_down_d[b];
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bank_clk_q <= '0;
      bank_reserved_q <= '0;
      gate_q <= '0;
      driver_out_q <= '0;
      bank_power_down_q <= '0;
      driver_power_down_q <= '0;
    end else begin
      bank_clk_q <= bank_clk_d;
      bank_reserved_q <= bank_reserved_d;
      gate_q <= gate_d;
      driver_out_q <= driver_out_d;
      bank_power_down_q <= bank_power_down_d;
      driver_power_down_q <= driver_power_down_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  bank_power_down_follow_a: assert property ($past(bank_cfg_q[6][BANK_POWER_DOWN_BIT]) == bank_power_down_q[6])
    else $error("bank power-down output does not follow its field");
  drv_pd_follow_a: assert property ($past(drv_en_q[2][DRV_PD_BIT]) == driver_power_down_q[2])
    else $error("driver power-down output does not follow its bit");
  low_bank_fan_a: assert property (bank_cfg_q[0][FAN_LSB +: 2] == FAN_NORMAL)
    else $error("fan-out field set on a bank without fan-out");
  bypass_gated_a: assert property (!bypass_q[BYP_G0_BIT] |-> !bypass0_act[4])
    else $error("bypass active without global enable");
  bypass_in0_a: assert property (bypass0_act[5] |=> bank_clk_q[5] == $past(sources.clock_input_0))
    else $error("bank does not carry clock input 0 in bypass");
  bypass_in1_a: assert property (bypass1_act[6] |=> bank_clk_q[6] == $past(sources.clock_input_1))
    else $error("bank does not carry clock input 1 in bypass");
  normal_src_a: assert property (bank_cfg_q[1][FAN_LSB +: 2] == FAN_NORMAL && bank_cfg_q[1][2:0] == SRC_FRAC1
    |=> bank_clk_q[1] == $past(sources.fractional_divider[1]))
    else $error("bank 1 does not follow fractional divider 1");
  int_src_a: assert property (bank_cfg_q[0][2:0] == SRC_INT0_DIV1 |=> bank_clk_q[0] == $past(sources.integer_divider[0]))
    else $error("bank 0 does not follow integer divider 0");
  frac_src_a: assert property (bank_cfg_q[3][2:0] == SRC_FRAC2 |=> bank_clk_q[3] == $past(sources.fractional_divider[2]))
    else $error("bank 3 does not follow fractional divider 2");
  reserved_low_a: assert property (bank_reserved_q[2] |-> !bank_clk_q[2])
    else $error("reserved source drives a clock");
  reserved_rd_a: assert property (req.rd && req.addr == BANK_CFG_BASE |=> rd_data_q[7:6] == 2'b00)
    else $error("reserved bank bits read nonzero");
  sync_hold_a: assert property (!drv_en_q[0][DRV_MODE_BIT] && bank_clk_q[0] ##1 bank_clk_q[0] |-> $stable(gate_q[0]))
    else $error("synchronous gate moved while clock high");
  async_now_a: assert property (drv_en_q[0][DRV_MODE_BIT] |=> gate_q[0] == !$past(drv_en_q[0][DRV_DIS_BIT]))
    else $error("asynchronous gate did not follow enable at once");

  bypass_seen_c: cover property (bypass0_act[4] ##1 bank_clk_q[4]);
  sync_on_c: cover property (!drv_en_q[1][DRV_MODE_BIT] && !gate_q[1] ##1 gate_q[1] ##1 driver_out_q[1]);
  reserved_c: cover property (bank_reserved_q[3]);
endmodule // obse_top

// >>> bench/tb_obse_top.sv
// Self-checking testbench for the output bank source and driver enable block
module tb_obse_top;
  timeunit 1ns;
  timeprecision 1ps;
  import obse_pkg::*;
  // ****************************************
  // Stimulus and design
  // ****************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  obse_req_t req = '0;
  obse_sources_t sources = '0;
  logic [7:0] rd_data_q;
  logic [6:0] bank_clk_q, bank_power_down_q, driver_power_down_q, driver_out_q, bank_reserved_q;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  obse_top obse_top_inst (.clk(clk), .reset_n(reset_n), .req(req), .rd_data_q(rd_data_q), .sources(sources),
    .bank_clk_q(bank_clk_q), .bank_power_down_q(bank_power_down_q), .driver_power_down_q(driver_power_down_q),
    .driver_out_q(driver_out_q), .bank_reserved_q(bank_reserved_q));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cbit(input string what, input logic exp, input logic got);
    cmp(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    cmp("read data", exp, rd_data_q);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Program a bank, drive sources, judge the bank clock and reserved flag
  task automatic chk_clk(input int b, input logic [7:0] cfg, input logic [11:0] m, input logic ec, input logic er);
    wr(BANK_CFG_BASE + 8'(b), cfg);
    sources <= obse_sources_t'(m);
    settle();
    cbit("bank clock", ec, bank_clk_q[b]);
    cbit("reserved flag", er, bank_reserved_q[b]);
  endtask
  // Zero mask marks a reserved code: all sources high, clock must stay low
  task automatic map_bank(input int b, input logic [11:0] m [8]);
    for (int c = 0; c < 8; c++) begin
      chk_clk(b, 8'(c), (m[c] == 12'h000) ? 12'hFFF : m[c], m[c] != 12'h000, m[c] == 12'h000);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd(BANK_CFG_BASE, BANK_CFG_RESET);
    rd(DRV_EN_BASE + 8'h06, 8'h00);
    wr(BANK_CFG_BASE, 8'hFF);
    rd(BANK_CFG_BASE, 8'h27);
    wr(BANK_CFG_BASE + 8'h04, 8'hFF);
    rd(BANK_CFG_BASE + 8'h04, 8'h3F);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    wr(DRV_EN_BASE, 8'hFF);
    rd(DRV_EN_BASE, 8'hC1);
    wr(DRV_EN_BASE, 8'h00);
    $display("Test registers done");
  endtask
  task automatic t_map();
    map_bank(5, '{12'h002, 12'h001, 12'h400, 12'h800, 12'h000, 12'h040, 12'h080, 12'h004});
    map_bank(0, '{12'h100, 12'h200, 12'h000, 12'h000, 12'h020, 12'h040, 12'h000, 12'h000});
    map_bank(3, '{12'h000, 12'h000, 12'h000, 12'h000, 12'h020, 12'h040, 12'h080, 12'h000});
    $display("Test source map done");
  endtask
  task automatic t_fan();
    wr(BYPASS_CFG_ADDR, 8'h03);
    chk_clk(4, 8'h0A, 12'h010, 1'b1, 1'b0);
    chk_clk(4, 8'h02, 12'h010, 1'b0, 1'b0);
    chk_clk(1, 8'h0D, 12'h010, 1'b0, 1'b0);
    wr(BYPASS_CFG_ADDR, 8'h01);
    chk_clk(4, 8'h0A, 12'h010, 1'b0, 1'b0);
    wr(BYPASS_CFG_ADDR, 8'h02);
    chk_clk(4, 8'h0A, 12'h010, 1'b0, 1'b0);
    wr(BYPASS_CFG_ADDR, 8'h0C);
    chk_clk(4, 8'h12, 12'h008, 1'b1, 1'b0);
    wr(BYPASS_CFG_ADDR, 8'h08);
    chk_clk(4, 8'h12, 12'h008, 1'b0, 1'b0);
    wr(BYPASS_CFG_ADDR, 8'h00);
    $display("Test fan-out done");
  endtask
  task automatic t_drv();
    chk_clk(1, 8'h05, 12'h040, 1'b1, 1'b0);
    cbit("driver out", 1'b1, driver_out_q[1]);
    wr(BANK_CFG_BASE + 8'h01, 8'h25);
    settle();
    cbit("bank power down", 1'b1, bank_power_down_q[1]);
    cbit("driver out", 1'b0, driver_out_q[1]);
    wr(DRV_EN_BASE + 8'h01, 8'h80);
    wr(BANK_CFG_BASE + 8'h01, 8'h05);
    settle();
    cbit("bank power down", 1'b0, bank_power_down_q[1]);
    cbit("driver power down", 1'b1, driver_power_down_q[1]);
    cbit("driver out", 1'b0, driver_out_q[1]);
    // Clock held high: a synchronous disable must wait for a falling edge
    wr(DRV_EN_BASE + 8'h01, 8'h01);
    settle();
    cbit("driver out", 1'b1, driver_out_q[1]);
    @(posedge clk);
    sources <= '0;
    settle();
    @(posedge clk);
    sources <= obse_sources_t'(12'h040);
    settle();
    cbit("driver out", 1'b0, driver_out_q[1]);
    wr(DRV_EN_BASE + 8'h01, 8'h40);
    settle();
    cbit("driver out", 1'b1, driver_out_q[1]);
    wr(DRV_EN_BASE + 8'h01, 8'h41);
    settle();
    cbit("driver out", 1'b0, driver_out_q[1]);
    $display("Test driver enable done");
  endtask
  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_map();
    t_fan();
    t_drv();
    conclude();
  end
endmodule // tb_obse_top
